// ==== bbd_core.sv ====
// Purpose: decode and execute branch, bit-set and bit-test-skip instructions
// Assumes: fetch presents the next word and its two-word flag each q4; memory read data is
//          valid by q3 for the address given in q2; all inputs on clk_sys_i
// Notes: program counter lives here; other opcodes just advance it
`timescale 1ns/100ps
`include "bbd_defs.svh"
module bbd_core #(
    parameter int PC_W = 21
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [15:0] instr_i,
    input wire logic instr_two_word_i,
    input wire logic ext_set_en_i,
    input wire logic [3:0] bank_selection_register_i,
    input wire logic [11:0] fsr2_base_i,
    input wire logic [7:0] rd_data_i,
    output logic [PC_W-1:0] pc_o,
    output logic [11:0] mem_addr_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [7:0] wr_data_o,
    output logic nop_exec_o,
    output logic [1:0] phase_o
);
    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        bbd_pkg::bbd_q_t q;
        bbd_pkg::bbd_ex_t ex;
        logic [15:0] ir;
        logic ir2;
        logic [PC_W-1:0] pc;
        logic [11:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
        logic nop;
    } bbd_state_t;

    bbd_state_t s_q;
    bbd_state_t s_d;

    logic [3:0] op4;
    logic [2:0] bidx;
    logic acc;
    logic [7:0] faddr;
    logic is_branch;
    logic is_set_bit;
    logic is_test;
    logic bitv;
    logic [PC_W-1:0] offs;

    ////////////////////////////////////////////////////////////////////////
    // field split of the executing word
    always_comb begin
        op4 = s_q.ir[`BBD_OP_HI:`BBD_OP_LO];
        bidx = s_q.ir[`BBD_BIT_HI:`BBD_BIT_LO];
        acc = s_q.ir[`BBD_ACC_POS];
        faddr = s_q.ir[`BBD_REG_HI:`BBD_FIELD_LO];
        // a discarded cycle decodes nothing, so a flushed word never acts
        is_branch = (s_q.ex == bbd_pkg::EX_NORMAL) &&
                    (s_q.ir[`BBD_OP_HI:`BBD_BRANCH_LO] == `BBD_OP_BRANCH_TOP);
        is_set_bit = (s_q.ex == bbd_pkg::EX_NORMAL) && (op4 == `BBD_OP_SET_BIT);
        is_test = (s_q.ex == bbd_pkg::EX_NORMAL) && ((op4 == `BBD_OP_BTC) || (op4 == `BBD_OP_BTS));
        bitv = rd_data_i[bidx];
        // sign-extended 11-bit offset times two
        offs = PC_W'({{(PC_W-`BBD_OFF_W){s_q.ir[`BBD_OFF_HI]}}, s_q.ir[`BBD_OFF_HI:`BBD_FIELD_LO]}
                     << `BBD_OFF_SHIFT);
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d = s_q;
        s_d.rd = 1'b0;
        s_d.wr = 1'b0;
        unique case (s_q.q)
            bbd_pkg::Q1: begin
                s_d.q = bbd_pkg::Q2;
                s_d.nop = (s_q.ex != bbd_pkg::EX_NORMAL);
            end
            bbd_pkg::Q2: begin
                s_d.q = bbd_pkg::Q3;
                if (is_set_bit || is_test) begin
                    // address formation: indexed, access bank or banked
                    if (!acc && ext_set_en_i && faddr <= `BBD_IDX_LIMIT) begin
                        s_d.addr = 12'(fsr2_base_i + 12'(faddr));
                    end else if (!acc) begin
                        // low part of the access bank maps to bank 0, the rest to the top bank
                        s_d.addr = {(faddr < `BBD_ACCESS_SPLIT) ? `BBD_ACC_LOW_BANK : `BBD_ACC_HIGH_BANK,
                                    faddr};
                    end else begin
                        s_d.addr = {bank_selection_register_i, faddr};
                    end
                    s_d.rd = 1'b1;
                end
            end
            // q3: merge the chosen bit into the read data
            bbd_pkg::Q3: begin
                s_d.q = bbd_pkg::Q4;
                if (is_set_bit) begin
                    s_d.wdata = rd_data_i | (`BBD_BIT_ONE << bidx);
                end
            end
            // q4: take the next word, step or load pc, decide on a skip
            bbd_pkg::Q4: begin
                s_d.q = bbd_pkg::Q1;
                s_d.ir = instr_i;
                s_d.ir2 = instr_two_word_i;
                s_d.ex = bbd_pkg::EX_NORMAL;
                s_d.pc = s_q.pc + PC_W'(`BBD_PC_STEP);
                if (is_set_bit) begin
                    s_d.wr = 1'b1;
                end
                if (is_branch) begin
                    // pc already points past the branch, so the offset is added to it
                    s_d.pc = s_q.pc + offs;
                    // the word fetched behind the branch is thrown away
                    s_d.ex = bbd_pkg::EX_FLUSH;
                end else if (is_test && ((op4 == `BBD_OP_BTC) ? !s_q.wdata[`BBD_TESTED_BIT]
                                                               : s_q.wdata[`BBD_TESTED_BIT])) begin
                    // a two-word victim needs one more discarded cycle for its second word
                    s_d.ex = instr_two_word_i ? bbd_pkg::EX_FLUSH2 : bbd_pkg::EX_FLUSH;
                end else if (s_q.ex == bbd_pkg::EX_FLUSH2) begin
                    s_d.ex = bbd_pkg::EX_FLUSH;
                end
            end
        endcase
        // latch tested bit in q3 for the q4 decision
        if (s_q.q == bbd_pkg::Q3 && is_test) begin
            s_d.wdata = 8'(bitv);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            // first cycle after reset is a discarded one while the first word is fetched
            s_q <= '{q: bbd_pkg::Q1, ex: bbd_pkg::EX_FLUSH, ir: '0, ir2: 1'b0, pc: PC_W'(`BBD_PC_RESET),
                     addr: '0, rd: 1'b0, wr: 1'b0, wdata: '0, nop: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign pc_o = s_q.pc;
    assign mem_addr_o = s_q.addr;
    assign mem_rd_o = s_q.rd;
    assign mem_wr_o = s_q.wr;
    assign wr_data_o = s_q.wdata;
    assign nop_exec_o = s_q.nop;
    assign phase_o = s_q.q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    // branch lands on its own address plus two plus twice the offset
    chk_branch_target: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (is_branch && s_q.q == bbd_pkg::Q4) |=> (pc_o == $past(s_q.pc) + $past(offs)))
        else $error("branch target wrong");

    // second branch cycle neither executes nor writes
    chk_branch_idle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (is_branch && s_q.q == bbd_pkg::Q4) |=> ##1 (nop_exec_o && !mem_wr_o)[*4])
        else $error("branch second cycle not idle");

    // a branch never reads data memory
    chk_branch_no_mem: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (is_branch && s_q.q == bbd_pkg::Q2) |=> !mem_rd_o)
        else $error("branch read data memory");

    // bit set writes back with the chosen bit high
    chk_set_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (is_set_bit && s_q.q == bbd_pkg::Q4) |=> (mem_wr_o && wr_data_o[$past(bidx)]))
        else $error("bit set missing");

    // all other bits of the write data follow the read data
    chk_set_keep: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (is_set_bit && s_q.q == bbd_pkg::Q3) |=>
            (wr_data_o == ($past(rd_data_i) | (`BBD_BIT_ONE << $past(bidx)))))
        else $error("bit set disturbed other bits");

    // write strobe follows the read strobe two clocks later
    chk_set_phase: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        mem_wr_o |-> (phase_o == bbd_pkg::Q1 && $past(mem_rd_o, 2)))
        else $error("bit set phase order wrong");

    // read strobe only stands in the third quarter
    chk_read_phase: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        mem_rd_o |-> (phase_o == bbd_pkg::Q3))
        else $error("read strobe out of phase");

    // write strobe is a single-clock pulse
    chk_write_pulse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        mem_wr_o |=> !mem_wr_o)
        else $error("write strobe too long");

    // banked access takes its bank from the bank selection input
    chk_bank_sel: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (mem_rd_o && $past(acc)) |->
            (mem_addr_o[`BBD_BANK_HI:`BBD_BANK_LO] == $past(bank_selection_register_i)))
        else $error("bank select not used");

    // unbanked access without the extended set goes to the access bank
    chk_access_bank: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (s_q.q == bbd_pkg::Q2 && (is_set_bit || is_test) && !acc && !ext_set_en_i) |=>
            (mem_addr_o[`BBD_BANK_HI:`BBD_BANK_LO] ==
             (($past(faddr) < `BBD_ACCESS_SPLIT) ? `BBD_ACC_LOW_BANK : `BBD_ACC_HIGH_BANK)))
        else $error("access bank not used");

    // low addresses with the extended set are offsets from the index base
    chk_idx_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (s_q.q == bbd_pkg::Q2 && (is_set_bit || is_test) && !acc && ext_set_en_i && faddr <= `BBD_IDX_LIMIT) |=>
            (mem_addr_o == 12'($past(fsr2_base_i) + 12'($past(faddr)))))
        else $error("indexed address wrong");

    // a taken skip turns the next cycle into a no-op
    chk_skip_nop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (is_test && s_q.q == bbd_pkg::Q4 && s_q.wdata[`BBD_TESTED_BIT] == (op4 == `BBD_OP_BTS)) |=>
            ##1 nop_exec_o)
        else $error("skip did not discard");

    // skipping a two-word word discards one more cycle
    chk_skip_two: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (s_q.ex == bbd_pkg::EX_FLUSH2 && s_q.q == bbd_pkg::Q4) |=> (s_q.ex == bbd_pkg::EX_FLUSH))
        else $error("two-word skip short");

    // an untaken skip lets the next word run
    chk_no_skip: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (is_test && s_q.q == bbd_pkg::Q4 && s_q.wdata[`BBD_TESTED_BIT] != (op4 == `BBD_OP_BTS)) |=>
            ##1 !nop_exec_o)
        else $error("skip taken wrongly");

    // a bit test never writes data memory
    chk_test_no_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (is_test && s_q.q == bbd_pkg::Q4) |=> !mem_wr_o)
        else $error("bit test wrote memory");

    // a skip discards the word but the program counter still steps by one word
    chk_skip_pc: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (is_test && s_q.q == bbd_pkg::Q4) |=> (pc_o == $past(s_q.pc) + PC_W'(`BBD_PC_STEP)))
        else $error("bit test moved pc wrongly");
endmodule : bbd_core

// ==== bbd_defs.svh ====
// Purpose: constants for the branch and bit-operation decoder
// Assumes: 16-bit instruction words, byte-addressed program counter
// Notes: included by bbd_core.sv
// Notes on behaviour
// - decode one-word branch, top five bits 11010, signed 11-bit offset.
// - branch loads pc with incremented address plus twice the signed offset.
// - branch takes two cycles; pc written in q4, second cycle idles.
// - bit set forces chosen bit of addressed register high, others kept.
// - access flag 0 selects access bank, 1 takes bank from bank select.
// - extended set, flag 0, address up to 5fh uses indexed literal offset.
// - skip-if-clear test skips next instruction when chosen bit is zero.
// - a taken skip discards the prefetched instruction and runs a no-op.
// - skip-if-set test skips next instruction when chosen bit is one.
`ifndef BBD_DEFS_SVH
`define BBD_DEFS_SVH
`define BBD_OP_BRANCH_TOP 5'h1a
`define BBD_OP_SET_BIT 4'h8
`define BBD_OP_BTC 4'hb
`define BBD_OP_BTS 4'ha
`define BBD_IDX_LIMIT 8'h5f
`define BBD_ACCESS_SPLIT 8'h60
`define BBD_ACC_HIGH_BANK 4'hf
`define BBD_ACC_LOW_BANK 4'h0
`define BBD_PC_RESET 21'h000000
`define BBD_PC_STEP 21'h000002
// field positions inside the executing word
`define BBD_OP_HI 15
`define BBD_OP_LO 12
`define BBD_BRANCH_LO 11
`define BBD_BIT_HI 11
`define BBD_BIT_LO 9
`define BBD_ACC_POS 8
`define BBD_REG_HI 7
`define BBD_FIELD_LO 0
// bank part of a data address
`define BBD_BANK_HI 11
`define BBD_BANK_LO 8
// branch offset width and scaling
`define BBD_OFF_W 11
`define BBD_OFF_HI 10
`define BBD_OFF_SHIFT 1
// single-bit mask seed and the bit that carries a test result
`define BBD_BIT_ONE 8'h01
`define BBD_TESTED_BIT 0
`endif

// ==== bbd_pkg.sv ====
// Purpose: types for the branch and bit-operation decoder
// Assumes: nothing beyond the defs header
// Notes: quarter phases of one instruction cycle
package bbd_pkg;
    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} bbd_q_t;
    typedef enum logic [1:0] {EX_NORMAL, EX_FLUSH, EX_FLUSH2} bbd_ex_t;
endpackage : bbd_pkg

// ==== tb_top.sv ====
// Purpose: self-checking bench for the branch and bit-operation decoder
// Assumes: one instruction per four clocks, word handed over while phase_o is 3
// Notes: every instruction is followed by a filler word that decodes as nothing
`timescale 1ns/100ps
module tb_top;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] instr_i = 16'h0000;
    logic instr_two_word_i = 1'b0;
    logic ext_set_en_i = 1'b0;
    logic [3:0] bank_selection_register_i = 4'h5;
    logic [11:0] fsr2_base_i = 12'h300;
    logic [7:0] rd_data_i = 8'h00;
    logic [20:0] pc_o, pc_a, dpc;
    logic [11:0] mem_addr_o, addr_seen;
    logic mem_rd_o, mem_wr_o, nop_exec_o, rd_seen, wr_seen, nop1, nop2;
    logic [7:0] wr_data_o, wd_seen;
    logic [1:0] phase_o;
    int error_cnt = 0;
    int n_checks = 0;

    // 250 MHz core clock
    always #2 clk_sys_i = ~clk_sys_i;

    bbd_core u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_i(instr_i), .instr_two_word_i(instr_two_word_i),
        .ext_set_en_i(ext_set_en_i), .bank_selection_register_i(bank_selection_register_i),
        .fsr2_base_i(fsr2_base_i), .rd_data_i(rd_data_i), .pc_o(pc_o), .mem_addr_o(mem_addr_o),
        .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .wr_data_o(wr_data_o), .nop_exec_o(nop_exec_o), .phase_o(phase_o));

    ////////////////////////////////////////////////////////////////////////////////
    // report, compare and run one instruction, sampling in quarters q1, q3 and q4
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask : chk

    task automatic exec(input logic [15:0] w, input logic tw);
        int k;
        k = 0;
        while (phase_o !== 2'h3 && k < 8) begin
            @(posedge clk_sys_i);
            #1 k++;
        end
        if (k == 8) begin
            error_cnt++;
            finish_test();
        end
        instr_i = w;
        for (int e = 1; e <= 12; e++) begin
            @(posedge clk_sys_i);
            #1;
            if (e == 3) {rd_seen, addr_seen} = {mem_rd_o, mem_addr_o};
            if (e == 4) {pc_a, instr_i, instr_two_word_i} = {pc_o, 16'h0000, tw};
            if (e == 5) {dpc, wr_seen, wd_seen} = {pc_o - pc_a, mem_wr_o, wr_data_o};
            if (e == 7) nop1 = nop_exec_o;
            if (e == 8) instr_two_word_i = 1'b0;
            if (e == 11) nop2 = nop_exec_o;
        end
    endtask : exec

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios: branch extremes, bit set over bank boundaries, all skip cases
    task automatic t_branch;
        logic [10:0] off [3] = '{11'h3ff, 11'h400, 11'h005};
        for (int i = 0; i < 3; i++) begin
            exec({5'h1a, off[i]}, 1'b0);
            chk(dpc === {{9{off[i][10]}}, off[i], 1'b0}, "branch target");
            chk(nop1 === 1'b1 && wr_seen === 1'b0, "branch idle cycle");
        end
    endtask : t_branch

    task automatic t_bit_set;
        logic [7:0] f;
        logic a;
        logic [11:0] ea;
        for (int b = 0; b < 8; b++) begin
            f = 8'h5c + 8'(b);
            a = (b >= 6);
            ext_set_en_i = (b % 2 == 1);
            rd_data_i = 8'h0a ^ 8'(b);
            ea = a ? {bank_selection_register_i, f} : (ext_set_en_i && f <= 8'h5f) ? fsr2_base_i + {4'h0, f}
                : {(f < 8'h60) ? 4'h0 : 4'hf, f};
            exec({4'h8, 3'(b), a, f}, 1'b0);
            chk(rd_seen === 1'b1 && addr_seen === ea, "bit set address");
            chk(wr_seen === 1'b1 && wd_seen === (rd_data_i | (8'h01 << b)), "bit set data");
            chk(dpc === 21'h000002 && nop1 === 1'b0, "bit set single cycle");
        end
    endtask : t_bit_set

    task automatic t_skip;
        logic [2:0] b;
        logic set, skip;
        logic [3:0] op;
        for (int i = 0; i < 8; i++) begin
            op = (i % 2 == 1) ? 4'hb : 4'ha;
            set = ((i / 2) % 2 == 1);
            b = 3'(i * 3);
            rd_data_i = set ? (8'h01 << b) : ~(8'h01 << b);
            skip = (op == 4'hb) ? !set : set;
            exec({op, b, 1'b1, 8'h20}, i >= 4);
            chk(nop1 === skip && dpc === 21'h000002, "skip decision");
            if (skip) chk(nop2 === (i >= 4), "skip length");
        end
    endtask : t_skip

    // reset for three cycles, then the scenarios
    initial begin
        repeat (3) @(posedge clk_sys_i);
        #1 rst_i = 1'b0;
        t_branch();
        t_bit_set();
        t_skip();
        finish_test();
    end
endmodule : tb_top
